// *** core/kee_encoder.sv ***
`timescale 1ns/100ps
`include "kee_regs.svh"
module kee_encoder (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  // configuration
  input wire logic protocol_select_i,
  // key matrix, bit row*12+col, 1 = pressed
  input wire logic [`KEE_KEYS-1:0] key_matrix_i,
  // three-wire link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic interrupt_out_n_o,
  output logic interrupt_oe_o,
  // queued code access for the I2C side
  input wire logic keycode_pop_i,
  output logic [`KEE_CODE_W-1:0] keycode_o,
  output logic fifo_not_empty_o,
  output logic fifo_overflow_o
);
  logic [`KEE_KEYS-1:0] key_s1, key_s2, reported, next_reported;
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2;
  logic scl_rise, ghost;
  logic [`KEE_ROW_W-1:0] row, next_row;
  logic [`KEE_COL_W-1:0] col, next_col;
  logic [`KEE_IDX_W-1:0] idx;
  logic push, fifo_full, fifo_pop, overflow, next_overflow;
  logic [`KEE_CODE_W-1:0] push_code;
  kee_pkg::kee_link_state_t st, next_st;
  logic [`KEE_CODE_W-1:0] shreg, next_shreg;
  logic [`KEE_BIT_CNT_W-1:0] bit_cnt, next_bit_cnt;
  logic next_sda, next_sda_oe, next_int_oe;

  assign scl_rise = scl_s2 && !scl_d;
  assign idx = `KEE_IDX_W'(row) * `KEE_IDX_W'(`KEE_COLS) + `KEE_IDX_W'(col);

  // ghost check: two rows sharing a column plus one more column in either
  always_comb
  begin
    logic [`KEE_COLS-1:0] ra, rb, both, any;
    ra = '0;
    rb = '0;
    both = '0;
    any = '0;
    ghost = 1'b0;
    for (int a = 0; a < `KEE_ROWS; a++)
      for (int b = a + 1; b < `KEE_ROWS; b++)
      begin
        ra = key_s2[a*`KEE_COLS +: `KEE_COLS];
        rb = key_s2[b*`KEE_COLS +: `KEE_COLS];
        both = ra & rb;
        any = ra | rb;
        if ((both != '0) && (any != (any & -any)))
          ghost = 1'b1;
      end
  end

  // scanner walks every key; a key whose state differs from the last
  // reported one yields exactly one code, and any number may be held unless two rows share a column and either has another key (ghost)
  always_comb
  begin
    next_col = (col == `KEE_COL_LAST) ? '0 : col + 1'b1;
    next_row = (col == `KEE_COL_LAST) ? row + 1'b1 : row;
    next_reported = reported;
    push = 1'b0;
    push_code = {!key_s2[idx], row, col + `KEE_COL_BASE};
    next_overflow = overflow;
    if (soft_reset_i)
    begin
      next_reported = '0;
      next_overflow = 1'b0;
      next_col = '0;
      next_row = '0;
    end
    else if (!ghost && (key_s2[idx] != reported[idx]))
    begin
      next_reported[idx] = key_s2[idx];
      push = 1'b1;
      // a full queue drops the code and marks the loss until reset
      if (fifo_full)
        next_overflow = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      key_s1 <= '0;
      key_s2 <= '0;
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      reported <= '0;
      row <= '0;
      col <= '0;
      overflow <= 1'b0;
    end
    else
    begin
      key_s1 <= key_matrix_i;
      key_s2 <= key_s1;
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      reported <= next_reported;
      row <= next_row;
      col <= next_col;
      overflow <= next_overflow;
    end
  end

  assign fifo_overflow_o = overflow;
  assign fifo_pop = protocol_select_i ? ((st == kee_pkg::KEE_REQ) && scl_rise && !sda_s2)
                                      : keycode_pop_i;

  kee_fifo #(
    .WIDTH(`KEE_CODE_W),
    .DEPTH(`KEE_FIFO_DEPTH),
    .AW(`KEE_FIFO_AW)
  ) u_queue (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .clear_i(soft_reset_i),
    .push_i(push && !fifo_full),
    .push_data_i(push_code),
    .full_o(fifo_full),
    .pop_i(fifo_pop),
    .head_o(keycode_o),
    .not_empty_o(fifo_not_empty_o)
  );

  // three-wire sender; the device changes data just after each clock rise
  // so the host can sample it on the following fall
  always_comb
  begin
    next_st = st;
    next_shreg = shreg;
    next_bit_cnt = bit_cnt;
    next_sda = sda_o;
    next_sda_oe = sda_oe_o;
    case (st)
      kee_pkg::KEE_IDLE:
        if (protocol_select_i && fifo_not_empty_o)
          next_st = kee_pkg::KEE_REQ;
      kee_pkg::KEE_REQ:
        if (scl_rise && !sda_s2)
        begin
          next_shreg = {keycode_o[`KEE_CODE_W-2:0], 1'b0};
          next_sda = keycode_o[`KEE_CODE_W-1];
          next_sda_oe = 1'b1;
          next_bit_cnt = '0;
          next_st = kee_pkg::KEE_SHIFT;
        end
      kee_pkg::KEE_SHIFT:
        if (scl_rise)
        begin
          next_bit_cnt = bit_cnt + 1'b1;
          if (bit_cnt == `KEE_NINTH_BIT)
          begin
            next_sda_oe = 1'b0;
            next_sda = 1'b0;
            next_st = kee_pkg::KEE_FIN;
          end
          else if (bit_cnt == `KEE_LAST_DATA_BIT)
            next_sda = 1'b0;
          else
          begin
            // rises 0..6 after the start bit carry bits 6..0, so all eight go out
            next_sda = shreg[`KEE_CODE_W-1];
            next_shreg = {shreg[`KEE_CODE_W-2:0], 1'b0};
          end
        end
      kee_pkg::KEE_FIN:
        next_st = kee_pkg::KEE_IDLE;
      default:
        next_st = kee_pkg::KEE_IDLE;
    endcase
    if (!protocol_select_i || soft_reset_i)
    begin
      next_st = kee_pkg::KEE_IDLE;
      next_sda_oe = 1'b0;
      next_sda = 1'b0;
    end
    next_int_oe = (next_st == kee_pkg::KEE_REQ) || (next_st == kee_pkg::KEE_SHIFT);
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st <= kee_pkg::KEE_IDLE;
      shreg <= '0;
      bit_cnt <= '0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      interrupt_oe_o <= 1'b0;
      interrupt_out_n_o <= 1'b1;
    end
    else
    begin
      st <= next_st;
      shreg <= next_shreg;
      bit_cnt <= next_bit_cnt;
      sda_o <= next_sda;
      sda_oe_o <= next_sda_oe;
      interrupt_oe_o <= next_int_oe;
      interrupt_out_n_o <= !next_int_oe;
    end
  end

  // code column field range checked at every push
  code_layout_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    push |-> (push_code[3:0] >= `KEE_COL_BASE) && (push_code[3:0] <= `KEE_COL_W'(`KEE_COLS)))
    else $error("key code column field out of range");
  release_bit_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    push |-> (push_code[`KEE_REL_BIT] == reported[idx]))
    else $error("release bit does not match old key state");
  ghost_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ghost |-> !push)
    else $error("code emitted during ghost combination");
  once_only_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    push && !soft_reset_i |=> reported[$past(idx)] == $past(key_s2[idx]))
    else $error("reported state not updated after code");
  tw_only_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !protocol_select_i |=> !interrupt_oe_o && !sda_oe_o)
    else $error("three-wire link active in I2C mode");
  int_request_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (st == kee_pkg::KEE_IDLE) && protocol_select_i && fifo_not_empty_o && !soft_reset_i
    |=> interrupt_oe_o && !interrupt_out_n_o)
    else $error("interrupt not asserted for queued code");
  ninth_zero_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (st == kee_pkg::KEE_SHIFT) && scl_rise && (bit_cnt == `KEE_LAST_DATA_BIT)
    && protocol_select_i && !soft_reset_i |=> sda_oe_o && !sda_o)
    else $error("ninth bit not zero");
  int_release_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (st == kee_pkg::KEE_SHIFT) && scl_rise && (bit_cnt == `KEE_NINTH_BIT)
    |=> interrupt_out_n_o && !interrupt_oe_o ##1 (st == kee_pkg::KEE_IDLE))
    else $error("interrupt not released after ninth bit");
  ovf_sticky_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    fifo_overflow_o && !soft_reset_i |=> fifo_overflow_o)
    else $error("overflow flag lost");
  rearm_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (st == kee_pkg::KEE_FIN) && fifo_not_empty_o && protocol_select_i && !soft_reset_i
    |=> ##1 !interrupt_out_n_o)
    else $error("interrupt not reasserted with codes pending");

  transfer_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (st == kee_pkg::KEE_SHIFT) ##[1:1000] (st == kee_pkg::KEE_FIN));
  ghost_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ghost && (key_s2[idx] != reported[idx]));
  overflow_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(fifo_overflow_o));
endmodule

// *** core/kee_regs.svh ***
`ifndef KEE_REGS_SVH
`define KEE_REGS_SVH

`define KEE_ROWS 8
`define KEE_COLS 12
`define KEE_KEYS 96
`define KEE_CODE_W 8
`define KEE_REL_BIT 7
`define KEE_ROW_W 3
`define KEE_COL_W 4
`define KEE_IDX_W 7
`define KEE_COL_LAST 4'hB
`define KEE_ROW_LAST 3'h7
`define KEE_COL_BASE 4'h1
`define KEE_BIT_CNT_W 4
`define KEE_LAST_DATA_BIT 4'h7
`define KEE_NINTH_BIT 4'h8
`define KEE_FIFO_DEPTH 16
`define KEE_FIFO_AW 4

`endif

// *** core/kee_pkg.sv ***
package kee_pkg;
  typedef enum logic [3:0] {
    KEE_IDLE  = 4'h1,
    KEE_REQ   = 4'h2,
    KEE_SHIFT = 4'h4,
    KEE_FIN   = 4'h8
  } kee_link_state_t;
endpackage

// *** core/kee_fifo.sv ***
`timescale 1ns/100ps
`include "kee_regs.svh"
module kee_fifo #(
  parameter int WIDTH = `KEE_CODE_W,
  parameter int DEPTH = `KEE_FIFO_DEPTH,
  parameter int AW = `KEE_FIFO_AW
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clear_i,
  // write side
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_data_i,
  output logic full_o,
  // read side
  input wire logic pop_i,
  output logic [WIDTH-1:0] head_o,
  output logic not_empty_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic [AW:0] count, next_count;
  logic [WIDTH-1:0] next_head;
  logic do_push, do_pop;

  // head register is fed from the slot the read pointer will point at,
  // with a bypass so a push into an empty queue is visible next cycle
  always_comb
  begin
    do_push = push_i && (count != (AW+1)'(DEPTH)) && !clear_i;
    do_pop = pop_i && (count != '0) && !clear_i;
    next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    if (clear_i)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end
    if (do_push && (next_rd_ptr == wr_ptr))
      next_head = push_data_i;
    else
      next_head = mem[next_rd_ptr];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (do_push)
      mem[wr_ptr] <= push_data_i;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
      head_o <= '0;
      full_o <= 1'b0;
      not_empty_o <= 1'b0;
    end
    else
    begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
      head_o <= next_head;
      full_o <= (next_count == (AW+1)'(DEPTH));
      not_empty_o <= (next_count != '0);
    end
  end
endmodule

// *** testbench/kee_host_model.sv ***
`timescale 1ns/100ps
module kee_host_model (
  // clock
  input wire logic clk_sys_i,
  // three-wire link, wire levels
  input wire logic int_n_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // serial clock stands low between frames
  initial
  begin
    scl_o = 1'b0;
    sda_low_o = 1'b0;
  end

  // half period of the 160 ns link clock; far faster than a real host
  // may run, which only shortens the run since the design has no minimum
  task automatic half();
    repeat (8) @(negedge clk_sys_i);
  endtask

  task automatic fetch(output logic [7:0] code, output logic ninth, output logic rel);
    int n;
    n = 0;
    code = 8'h00;
    ninth = 1'b1;
    rel = 1'b0;
    while (int_n_i !== 1'b0 && n < 400)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    // start bit: data line low across the first rise
    sda_low_o = 1'b1;
    half();
    scl_o = 1'b1;
    // sample each bit on the falling edge, msb first
    for (int i = 0; i < 9; i++)
    begin
      half();
      if (i < 8)
        code = {code[6:0], sda_i};
      else
        ninth = sda_i;
      scl_o = 1'b0;
      sda_low_o = 1'b0;
      half();
      scl_o = 1'b1;
    end
    // release may be brief when more codes wait, so look every cycle
    repeat (8)
    begin
      @(negedge clk_sys_i);
      if (int_n_i === 1'b1)
        rel = 1'b1;
    end
    scl_o = 1'b0;
  endtask
endmodule

// *** testbench/kee_encoder_tb_top.sv ***
`timescale 1ns/100ps
`include "kee_regs.svh"
module kee_encoder_tb_top;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic soft_reset_i = 1'b0;
  logic protocol_select_i = 1'b1;
  logic keycode_pop_i = 1'b0;
  logic [`KEE_KEYS-1:0] key_matrix_i = '0;
  logic scl, host_low, sda_o, sda_oe, int_n, int_oe, ne, ovf;
  logic [7:0] keycode;
  // pull-ups on both lines
  wire logic sda_w = sda_oe ? sda_o : !host_low;
  wire logic int_w = int_oe ? 1'b0 : 1'b1;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;

  kee_encoder DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .soft_reset_i(soft_reset_i),
    .protocol_select_i(protocol_select_i), .key_matrix_i(key_matrix_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .interrupt_out_n_o(int_n),
    .interrupt_oe_o(int_oe), .keycode_pop_i(keycode_pop_i), .keycode_o(keycode),
    .fifo_not_empty_o(ne), .fifo_overflow_o(ovf));
  kee_host_model HOST (.clk_sys_i(clk_sys_i), .int_n_i(int_w), .sda_i(sda_w),
    .scl_o(scl), .sda_low_o(host_low));

  initial
  begin
    forever #5 clk_sys_i = !clk_sys_i;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic do_reset(input logic mode);
    @(negedge clk_sys_i);
    reset_n_i = 1'b0;
    // protocol changes only while the block is held in reset
    protocol_select_i = mode;
    repeat (12) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
  endtask

  task automatic t_reset();
    check("int wire", int_w, 1'b1);
    check("int enable", int_oe, 1'b0);
    check("int level", int_n, 1'b1);
    check("data enable", sda_oe, 1'b0);
    check("not empty", ne, 1'b0);
    check("overflow", ovf, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_key(input int r, input int c);
    logic [7:0] code;
    logic ninth, rel;
    for (int p = 0; p < 2; p++)
    begin
      @(negedge clk_sys_i);
      key_matrix_i[r*12+c] = (p == 0);
      // a full scan plus the synchroniser has passed, so the request stands
      repeat (120) @(negedge clk_sys_i);
      check("int level", int_n, 1'b0);
      HOST.fetch(code, ninth, rel);
      check("code", code, {p[0], r[2:0], c[3:0] + 4'h1});
      check("ninth bit", ninth, 1'b0);
      check("released", rel, 1'b1);
    end
    // unchanged keys send nothing more
    repeat (200) @(negedge clk_sys_i);
    check("idle queue", ne, 1'b0);
    $display("test key done");
  endtask

  task automatic t_multi();
    logic [7:0] exp [4] = '{8'h03, 8'h35, 8'h83, 8'hB5};
    logic [7:0] c0, c1;
    logic ninth, rel;
    for (int j = 0; j < 4; j += 2)
    begin
      @(negedge clk_sys_i);
      key_matrix_i[2] = (j == 0);
      key_matrix_i[40] = (j == 0);
      HOST.fetch(c0, ninth, rel);
      HOST.fetch(c1, ninth, rel);
      // the scanner position decides which of the two keys leaves first
      check("queued code lo", (c0 < c1) ? c0 : c1, exp[j]);
      check("queued code hi", (c0 < c1) ? c1 : c0, exp[j+1]);
    end
    $display("test multi done");
  endtask

  task automatic t_ghost();
    for (int j = 0; j < 2; j++)
    begin
      @(negedge clk_sys_i);
      key_matrix_i[0] = (j == 0);
      key_matrix_i[1] = (j == 0);
      key_matrix_i[12] = (j == 0);
      repeat (300) @(negedge clk_sys_i);
      check("ghost int", int_w, 1'b1);
      check("ghost queue", ne, 1'b0);
    end
    $display("test ghost done");
  endtask

  task automatic t_i2c();
    // protocol chosen only under reset
    do_reset(1'b0);
    // one key at a time, a full scan apart, so the queue order is fixed
    for (int k = 0; k < 24; k++)
    begin
      key_matrix_i[k % 12] = (k < 12);
      repeat (110) @(negedge clk_sys_i);
    end
    check("i2c int", int_w, 1'b1);
    check("overflow", ovf, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      @(negedge clk_sys_i);
      check("not empty", ne, 1'b1);
      check("head", keycode, i < 12 ? 8'(i + 1) : 8'(8'h80 + i - 11));
      keycode_pop_i = 1'b1;
      @(negedge clk_sys_i);
      keycode_pop_i = 1'b0;
    end
    check("drained", ne, 1'b0);
    check("sticky", ovf, 1'b1);
    soft_reset_i = 1'b1;
    @(negedge clk_sys_i);
    soft_reset_i = 1'b0;
    @(negedge clk_sys_i);
    check("cleared", ovf, 1'b0);
    $display("test i2c done");
  endtask

  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      wrap_up();
    end
  end

  initial
  begin
    do_reset(1'b1);
    t_reset();
    t_key(0, 0);
    t_key(7, 11);
    t_key(3, 5);
    t_multi();
    t_ghost();
    t_i2c();
    wrap_up();
  end
endmodule
